// ===== common/gsr_pkg.sv
// package: record layout, register map and types of the status record block
package gsr_pkg;
    // record columns (1-based as printed)
    localparam int COL_ROLE   = 1;
    localparam int COL_ADDR   = 3;
    localparam int COL_CHG    = 6;
    localparam int COL_STATE  = 9;
    localparam int COL_SRQ    = 11;
    localparam int COL_ERR    = 14;
    localparam int COL_TRIG   = 18;
    localparam int COL_CLR    = 21;
    localparam int COL_XFER   = 24;
    localparam int COL_MSG    = 27;
    localparam int MSG_LEN    = 45;
    localparam int REC_LEN    = 75;
    localparam int ADDR_MAX   = 30;

    // register offsets
    localparam logic [7:0] REG_CTRL    = 8'h00;
    localparam logic [7:0] REG_ERR     = 8'h01;
    localparam logic [7:0] REG_CMD     = 8'h02;
    localparam logic [7:0] REG_MSGWR   = 8'h03;
    localparam logic [7:0] REG_IRQST   = 8'h04;
    localparam logic [7:0] REG_IRQCLR  = 8'h05;
    localparam logic [7:0] REG_IRQEN   = 8'h06;
    localparam logic [7:0] REG_RECBASE = 8'h80;

    // control register fields
    localparam int CTRL_ROLE_BIT  = 0;
    localparam int CTRL_ADDR_LSB  = 8;
    localparam int CTRL_XFER_LSB  = 16;
    // command register bits (write one to act)
    localparam int CMD_SVCREQ = 0;
    localparam int CMD_SPOLL  = 1;
    localparam int CMD_RSTTC  = 2;
    // interrupt bits
    localparam int IRQ_CHG  = 0;
    localparam int IRQ_SRQ  = 1;
    localparam int IRQ_TRIG = 2;
    localparam int IRQ_CLR  = 3;

    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [7:0]  ERR_RESET  = 8'h00;

    localparam logic [7:0] CH_SPACE = 8'h20;
    localparam logic [7:0] CH_ZERO  = 8'h30;

    typedef enum logic [1:0] {GSR_IDLE, GSR_TALK, GSR_LISTEN} gsr_addr_state_t;
    typedef enum logic [1:0] {GSR_XNONE, GSR_XCONT, GSR_XAUTO} gsr_xfer_t;

    typedef struct packed {
        logic       trigCmd;
        logic       clearCmd;
        logic       srqLine;
        logic       talkAddr;
        logic       listenAddr;
        logic       polledByCtrl;
    } gsr_bus_ev_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } gsr_reg_req_t;
endpackage

// ===== hdl/gsr_status_record.sv
// status record builder for an instrument bus interface board
//
// Added by the designer: the register addresses and the plain strobed port.
module gsr_status_record
    import gsr_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         resetn,
    input  wire gsr_reg_req_t req,
    input  wire gsr_bus_ev_t  busEv,
    output logic [31:0]       rdata,
    output logic              irq
);
    // pins from the bus pass two flops
    typedef struct packed {
        gsr_bus_ev_t         s1;
        gsr_bus_ev_t         s2;
        gsr_bus_ev_t         s3;
        logic                role;
        logic [4:0]          myAddr;
        gsr_xfer_t           xfer;
        logic [6:0]          errCode;
        gsr_addr_state_t     aState;
        logic                ctrlRole;
        logic                chg;
        logic                srqFlag;
        logic                trig;
        logic                clr;
        logic [3:0]          irqSt;
        logic [3:0]          irqEn;
        logic [MSG_LEN-1:0][7:0] msg;
        logic [31:0]         rdata;
        logic                irq;
    } gsr_state_t;

    gsr_state_t q, d;

    function automatic logic [15:0] twoDigits(input logic [6:0] v);
        logic [6:0] t;
        logic [6:0] o;
        t = v / 7'd10;
        o = v % 7'd10;
        return {CH_ZERO + {1'b0, t}, CH_ZERO + {1'b0, o}};
    endfunction

    function automatic logic [7:0] recChar(input gsr_state_t s, input int col);
        logic [15:0] ad;
        logic [15:0] ec;
        logic [7:0]  c;
        ad = twoDigits({2'b00, s.myAddr});
        ec = twoDigits(s.errCode);
        c  = CH_SPACE;
        if (col == COL_ROLE) c = s.role ? "C" : "P";
        else if (col == COL_ADDR) c = ad[15:8];
        else if (col == COL_ADDR + 1) c = ad[7:0];
        else if (col == COL_CHG) c = "G";
        else if (col == COL_CHG + 1) c = s.chg ? "1" : "0";
        else if (col == COL_STATE) begin
            unique case (s.aState)
                GSR_TALK:   c = "T";
                GSR_LISTEN: c = "L";
                default:    c = "I";
            endcase
        end
        else if (col == COL_SRQ) c = "S";
        else if (col == COL_SRQ + 1) c = s.srqFlag ? "1" : "0";
        else if (col == COL_ERR) c = "E";
        else if (col == COL_ERR + 1) c = ec[15:8];
        else if (col == COL_ERR + 2) c = ec[7:0];
        else if (col == COL_TRIG) c = "T";
        else if (col == COL_TRIG + 1) c = s.trig ? "1" : "0";
        else if (col == COL_CLR) c = "C";
        else if (col == COL_CLR + 1) c = s.clr ? "1" : "0";
        else if (col == COL_XFER) c = "P";
        else if (col == COL_XFER + 1) begin
            unique case (s.xfer)
                GSR_XCONT: c = "1";
                GSR_XAUTO: c = "2";
                default:   c = "0";
            endcase
        end
        else if (col >= COL_MSG && col < COL_MSG + MSG_LEN)
            c = s.msg[col - COL_MSG];
        else if (col > REC_LEN) c = 8'h00;
        return c;
    endfunction

    logic [7:0]      nextCh;
    gsr_addr_state_t newState;
    logic            polled;
    logic            pollCall;
    logic            svcCall;
    logic            recRead;
    int              col;

    always_comb begin
        d = q;
        d.s1 = busEv;
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.rdata = 32'h0000_0000;
        newState = q.s2.talkAddr ? GSR_TALK : (q.s2.listenAddr ? GSR_LISTEN : GSR_IDLE);
        polled   = q.s2.polledByCtrl && !q.s3.polledByCtrl;
        pollCall = req.wr && req.addr == REG_CMD && req.wdata[CMD_SPOLL];
        svcCall  = req.wr && req.addr == REG_CMD && req.wdata[CMD_SVCREQ];
        recRead  = req.rd && req.addr >= REG_RECBASE;
        col      = 0;
        nextCh   = CH_SPACE;

        // register writes
        if (req.wr) begin
            unique case (req.addr)
                REG_CTRL: begin
                    d.role = req.wdata[CTRL_ROLE_BIT];
                    // out-of-range address is clamped to the highest legal one
                    d.myAddr = (req.wdata[CTRL_ADDR_LSB +: 5] > 5'(ADDR_MAX)) ?
                               5'(ADDR_MAX) : req.wdata[CTRL_ADDR_LSB +: 5];
                    d.xfer = (req.wdata[CTRL_XFER_LSB +: 2] == 2'd3) ? GSR_XNONE :
                             gsr_xfer_t'(req.wdata[CTRL_XFER_LSB +: 2]);
                end
                REG_ERR: d.errCode = (req.wdata[6:0] > 7'd99) ? 7'd99 : req.wdata[6:0];
                REG_MSGWR: begin
                    if (req.wdata[15:8] < 8'(MSG_LEN))
                        d.msg[req.wdata[15:8]] = req.wdata[7:0];
                end
                REG_IRQEN: d.irqEn = req.wdata[3:0];
                default: ;
            endcase
        end

        // trigger and clear flags; reset command clears them unless frozen
        if (req.wr && req.addr == REG_CMD && req.wdata[CMD_RSTTC] && q.xfer != GSR_XCONT) begin
            d.trig = 1'b0;
            d.clr  = 1'b0;
        end
        if (q.xfer != GSR_XCONT) begin
            if (q.s2.trigCmd) d.trig = 1'b1;
            if (q.s2.clearCmd) d.clr = 1'b1;
        end

        // change flag: read clears, a new change in the same cycle wins
        if (recRead) d.chg = 1'b0;
        if (newState != q.aState || q.role != q.ctrlRole) d.chg = 1'b1;
        d.aState   = newState;
        d.ctrlRole = q.role;

        // service request flag
        if (q.role) begin
            // controller: follow rising SRQ, but a poll drops it even if SRQ stays
            if (q.s2.srqLine && !q.s3.srqLine) d.srqFlag = 1'b1;
            if (!q.s2.srqLine) d.srqFlag = 1'b0;
            if (pollCall) d.srqFlag = 1'b0;
        end else begin
            if (polled) d.srqFlag = 1'b0;
            if (svcCall) d.srqFlag = 1'b1;
        end

        // interrupt status: set wins over clear
        if (req.wr && req.addr == REG_IRQCLR) d.irqSt = q.irqSt & ~req.wdata[3:0];
        if (d.chg && !q.chg) d.irqSt[IRQ_CHG] = 1'b1;
        if (d.srqFlag && !q.srqFlag) d.irqSt[IRQ_SRQ] = 1'b1;
        if (d.trig && !q.trig) d.irqSt[IRQ_TRIG] = 1'b1;
        if (d.clr && !q.clr) d.irqSt[IRQ_CLR] = 1'b1;
        d.irq = |(d.irqSt & d.irqEn);

        // reads: record bytes at base + column - 1
        if (req.rd) begin
            if (recRead) begin
                col = int'(req.addr - REG_RECBASE) + 1;
                nextCh = recChar(q, col);
                d.rdata = {24'h00_0000, nextCh};
            end else begin
                unique case (req.addr)
                    REG_CTRL: d.rdata = {14'h0000, q.xfer, 3'b000, q.myAddr,
                                         7'h00, q.role};
                    REG_ERR:   d.rdata = {25'h000_0000, q.errCode};
                    REG_IRQST: d.rdata = {28'h000_0000, q.irqSt};
                    REG_IRQEN: d.rdata = {28'h000_0000, q.irqEn};
                    default:   d.rdata = 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
            q.role <= CTRL_RESET[CTRL_ROLE_BIT];
            q.errCode <= ERR_RESET[6:0];
            q.msg <= {MSG_LEN{CH_SPACE}};
        end else begin
            q <= d;
        end
    end

    assign rdata = q.rdata;
    assign irq   = q.irq;
endmodule

// ===== dv/gsr_status_record_properties.sv
// checker: record columns and read port of the status record block
module gsr_status_record_properties
    import gsr_pkg::*;
(
    input wire logic         clk,
    input wire logic         resetn,
    input wire gsr_reg_req_t req,
    input wire gsr_bus_ev_t  busEv,
    input wire logic [31:0]  rdata,
    input wire logic         irq
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking dc @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence rdAt(int c);
        req.rd && req.addr == 8'(c + 127);
    endsequence
    property colIs(int c, logic [7:0] ch);
        rdAt(c) |=> rdata == {24'h00_0000, ch};
    endproperty
    a_role_char: assert property (rdAt(1) |=> rdata[7:0] inside {8'h43, 8'h50})
        else $error("role column not C or P");
    a_addr_tens: assert property (rdAt(3) |=> rdata[7:0] inside {[8'h30:8'h33]})
        else $error("address tens digit out of range");
    a_chg_letter: assert property (colIs(6, 8'h47))
        else $error("change field letter wrong");
    a_state_char: assert property (rdAt(9) |=> rdata[7:0] inside {8'h54, 8'h4C, 8'h49})
        else $error("state column not T, L or I");
    a_srq_letter: assert property (colIs(11, 8'h53))
        else $error("service request letter wrong");
    a_err_letter: assert property (colIs(14, 8'h45))
        else $error("error field letter wrong");
    a_xfer_letter: assert property (colIs(24, 8'h50))
        else $error("transfer field letter wrong");
    a_gap_space: assert property (colIs(2, CH_SPACE))
        else $error("gap column not a space");
    a_past_record: assert property (req.rd && req.addr > 8'hCA |=> rdata == 32'h0000_0000)
        else $error("read beyond record not zero");
    // read data must not linger, a reader could take a stale byte
    a_rdata_idle: assert property (!$past(req.rd) |-> rdata == 32'h0000_0000)
        else $error("read data outside read answer");
endmodule
bind gsr_status_record gsr_status_record_properties chk_u (.clk(clk), .resetn(resetn),
    .req(req), .busEv(busEv), .rdata(rdata), .irq(irq));

// ===== dv/tb_top.sv
// testbench: register bus and status record checks
module tb_top
    import gsr_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic         clk, resetn, irq, role, chg, srq, trig, clr;
    logic [31:0]  rdata, lfsr, r, v;
    gsr_reg_req_t req;
    gsr_bus_ev_t  busEv;
    logic [4:0]   adr;
    logic [1:0]   xf;
    logic [6:0]   ec;
    logic [7:0]   st, idx;
    logic [7:0]   msg [45];
    int           errTotal, numChecks;
    gsr_status_record dut_u (.clk(clk), .resetn(resetn), .req(req), .busEv(busEv),
        .rdata(rdata), .irq(irq));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    function automatic logic [31:0] nextRand();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction
    function automatic logic [7:0] dig(int n);
        return CH_ZERO + 8'(n);
    endfunction
    function automatic logic [7:0] expCol(int c);
        case (c)
            1: return role ? 8'h43 : 8'h50;
            3: return dig(adr / 10);
            4: return dig(adr % 10);
            6: return 8'h47;
            7: return dig(chg);
            9: return st;
            11: return 8'h53;
            12: return dig(srq);
            14: return 8'h45;
            15: return dig(ec / 10);
            16: return dig(ec % 10);
            18: return 8'h54;
            19: return dig(trig);
            21: return 8'h43;
            22: return dig(clr);
            24: return 8'h50;
            25: return dig(xf);
            default: return (c >= 27 && c < 72) ? msg[c - 27] : CH_SPACE;
        endcase
    endfunction
    task automatic wrapUp();
        $display("checks %0d errors %0d", numChecks, errTotal);
        if (errTotal == 0 && numChecks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        numChecks++;
        if (got !== exp) begin
            errTotal++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        req.addr <= a;
        req.wdata <= d;
        req.wr <= 1'b1;
        @(posedge clk);
        req.wr <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge clk);
        req.rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic chkCol(int c);
        rd(8'(c + 127), v);
        chk(v, {24'h00_0000, expCol(c)});
    endtask
    task automatic chkRec();
        chkCol(6);
        chg = 1'b0;
        for (int c = 1; c <= REC_LEN; c++) chkCol(c);
    endtask
    task automatic chkIrq(logic e);
        repeat (2) @(posedge clk);
        #1 chk(32'(irq), 32'(e));
    endtask
    task automatic setCtrl(logic ro, logic [4:0] a, logic [1:0] x);
        wr(REG_CTRL, {14'h0000, x, 3'h0, a, 7'h00, ro});
        chg = chg | (ro != role);
        role = ro;
        adr = (a > ADDR_MAX) ? 5'(ADDR_MAX) : a;
        xf = (x == 2'h3) ? 2'h0 : x;
    endtask
    // wait covers the two sync flops plus the flag register
    task automatic pulse(int b);
        @(posedge clk);
        busEv <= gsr_bus_ev_t'(6'(busEv) | 6'(1 << b));
        repeat (4) @(posedge clk);
        busEv <= gsr_bus_ev_t'(6'(busEv) & ~6'(1 << b));
        repeat (4) @(posedge clk);
    endtask
    initial begin
        #(25ns * 30000);
        errTotal++;
        wrapUp();
    end
    initial begin
        resetn = 1'b0;
        req = '0;
        busEv = '0;
        lfsr = 32'h0001_330D;
        {role, chg, srq, trig, clr, adr, xf, ec} = '0;
        st = 8'h49;
        foreach (msg[i]) msg[i] = CH_SPACE;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        chkRec();
        rd(8'h40, v);
        chk(v, 32'h0000_0000);
        rd(8'hCB, v);
        chk(v, 32'h0000_0000);
        setCtrl(1'b1, 5'h1F, 2'h3);
        wr(REG_ERR, 32'h0000_007F);
        ec = 7'd99;
        rd(REG_CTRL, v);
        chk(v, 32'h0000_1E01);
        rd(REG_ERR, v);
        chk(v, 32'h0000_0063);
        chkRec();
        for (int i = 0; i < 12; i++) begin
            r = nextRand();
            setCtrl(r[0], r[12:8], r[17:16]);
            wr(REG_ERR, {25'h000_0000, r[30:24]});
            ec = (r[30:24] > 7'd99) ? 7'd99 : r[30:24];
            idx = 8'(r[23:16] % 50);
            wr(REG_MSGWR, {16'h0000, idx, 3'h2, r[4:0]});
            if (idx < MSG_LEN) msg[idx] = {3'h2, r[4:0]};
            chkRec();
            chkIrq(1'b0);
        end
        for (int k = 1; k < 5; k++) begin
            @(posedge clk);
            busEv.talkAddr <= k[1];
            busEv.listenAddr <= k[0];
            repeat (4) @(posedge clk);
            chg = (st != (k[1] ? 8'h54 : k[0] ? 8'h4C : 8'h49));
            st = k[1] ? 8'h54 : k[0] ? 8'h4C : 8'h49;
            chkCol(7);
            chg = 1'b0;
            chkCol(9);
            chkCol(7);
        end
        wr(REG_IRQCLR, 32'h0000_000F);
        wr(REG_IRQEN, 32'h0000_0008);
        setCtrl(role, adr, 2'h1);
        pulse(5);
        chkCol(19);
        setCtrl(role, adr, 2'h0);
        pulse(5);
        trig = 1'b1;
        chkIrq(1'b0);
        rd(REG_IRQST, v);
        chk(v, 32'h0000_0004);
        pulse(4);
        clr = 1'b1;
        chkIrq(1'b1);
        setCtrl(role, adr, 2'h1);
        wr(REG_CMD, 32'h0000_0004);
        chkCol(19);
        chkCol(22);
        setCtrl(role, adr, 2'h2);
        wr(REG_CMD, 32'h0000_0004);
        {trig, clr} = 2'b00;
        chkCol(19);
        chkCol(22);
        wr(REG_IRQCLR, 32'h0000_000C);
        chkIrq(1'b0);
        setCtrl(1'b0, adr, 2'h0);
        wr(REG_CMD, 32'h0000_0001);
        srq = 1'b1;
        chkCol(12);
        pulse(0);
        srq = 1'b0;
        chkCol(12);
        setCtrl(1'b1, adr, 2'h0);
        busEv.srqLine <= 1'b1;
        repeat (4) @(posedge clk);
        srq = 1'b1;
        chkCol(12);
        wr(REG_CMD, 32'h0000_0002);
        srq = 1'b0;
        chkCol(12);
        wrapUp();
    end
endmodule
